// File: core/efr_cfg.svh
// efr_cfg.svh: register map, field positions and reset values of the
// egress rewriter tables.
// assumes a byte-addressed 32-bit register bus, one aligned word per register.
// Behaviour
// - mapped DEI is map entry bit 3
// - mapped PCP is map entry bits 2:0
// - map table used only when source is mapped
// - source value 2 selects the mapped value
// - backplane bit inserts rx stamp at byte 16
// - one-step disable drops one-step and origin commands
// - two-step disable drops departure time saving
// - one-step frames add signed port delay when flagged
// - high-drop table remaps when mode 3, dp 1
// - normal table for mode 2, mode 3 dp 0
// - statistics set chosen by two-bit mode
// - protection status held in three 32-bit words
// - protection group picked by the frame's protection group index
// - status bit 0 working, 1 protected path
`ifndef EFR_CFG_SVH
`define EFR_CFG_SVH
// per-port register groups
`define EFR_PORT_SHIFT   7
`define EFR_MAP_OFS      7'h10
`define EFR_MAP_END      7'h50
`define EFR_PTP_OFS      7'h50
`define EFR_DLY_OFS      7'h54
// shared register groups
`define EFR_PROT_BASE    12'h680
`define EFR_PROT_WORDS   2'h3
`define EFR_COM_BASE     12'h690
`define EFR_RMP_OFS      12'h100
`define EFR_STAT_OFS     12'h200
// field positions and masks
`define EFR_MAP_DEI_BIT  3
`define EFR_MAP_MASK     4'hF
`define EFR_PTP_BP_BIT   7
`define EFR_PTP_1S_BIT   2
`define EFR_PTP_2S_BIT   1
`define EFR_PTP_MASK     8'h86
`define EFR_PPT2_MASK    32'h00000FFF
`define EFR_PROT_GROUPS  7'h4C
`define EFR_REWOP_DLY    5
`define EFR_BP_TS_OFS    8'h10
// field encodings
`define EFR_SRC_CLS      2'h0
`define EFR_SRC_FIXED    2'h1
`define EFR_SRC_MAPPED   2'h2
`define EFR_DSCP_KEEP    2'h0
`define EFR_DSCP_ANA     2'h1
`define EFR_DSCP_RMP     2'h2
`define EFR_DSCP_DP      2'h3
`define EFR_STAT_ES_IS   2'h0
`define EFR_STAT_ES_ONLY 2'h1
`define EFR_STAT_IS      2'h2
`define EFR_REG_RESET    32'h00000000
`endif

// File: core/efr_pkg.sv
// efr_pkg.sv: types shared by the egress rewriter tables.
// assumes efr_cfg.svh for numeric constants.
package efr_pkg;
    typedef enum logic [2:0] {
        EFR_REG_NONE = 3'h0, EFR_REG_MAP = 3'h1, EFR_REG_PTP = 3'h2, EFR_REG_DLY = 3'h3,
        EFR_REG_PROT = 3'h4, EFR_REG_DP1 = 3'h5, EFR_REG_RMP = 3'h6, EFR_REG_STAT = 3'h7
    } efr_reg_type;
    typedef enum logic [1:0] {
        EFR_PTP_NONE = 2'h0, EFR_PTP_ONE = 2'h1, EFR_PTP_TWO = 2'h2, EFR_PTP_ORIGIN = 2'h3
    } efr_ptp_cmd_type;
    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } efr_avs_req_type;
    typedef struct packed {
        efr_reg_type kind;
        logic [3:0]  port;
        logic [5:0]  idx;
    } efr_dec_type;
    typedef struct packed {
        logic [3:0]      port;
        logic [3:0]      source_port_number;
        logic            dp;
        logic [2:0]      qos;
        logic [1:0]      tag_pcp_src;
        logic [1:0]      tag_dei_src;
        logic [2:0]      cls_pcp;
        logic            cls_dei;
        logic [2:0]      port_pcp;
        logic            port_dei;
        logic [1:0]      dscp_mode;
        logic [5:0]      dscp;
        efr_ptp_cmd_type ptp_cmd;
        logic [5:0]      rewrite_op;
        logic [31:0]     rx_ts;
        logic [31:0]     residence;
        logic            egress_lookup_hit;
        logic [9:0]      egress_service_index;
        logic [9:0]      ingress_service_index;
        logic [6:0]      protection_group_index;
    } efr_meta_type;
    typedef struct packed {
        logic [3:0]  port;
        logic [2:0]  pcp;
        logic        dei;
        logic        dscp_upd;
        logic [5:0]  dscp;
        logic        bp_ts_ins;
        logic [7:0]  bp_ts_ofs;
        logic [31:0] rx_ts;
        logic        one_step;
        logic        origin;
        logic        save_departure;
        logic [31:0] residence;
        logic        stat_ena;
        logic [9:0]  stat_idx;
        logic        protected_path;
    } efr_edit_type;
endpackage : efr_pkg

// File: core/efr_rewriter_tables.sv
// efr_rewriter_tables.sv: egress rewriter tables with Avalon-MM register slave,
// per-frame decision logic and an output FIFO.
// assumes frame metadata arrives synchronous to i_clk with valid/ready handshake.
`include "efr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module efr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_in_valid,
    output var  logic             o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output var  logic             o_out_valid,
    input  wire logic             i_out_ready,
    output var  logic [WIDTH-1:0] o_out_data
);
    typedef struct packed {
        logic                        rdy;
        logic [DEPTH-1:0]            vld;
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } efr_fifo_state_type;

    efr_fifo_state_type s;
    efr_fifo_state_type next_s;
    logic               pop;
    logic               push;
    logic               placed;

    // shift fifo: head always in slot 0 so outputs come from flops
    always_comb begin
        next_s = s;
        pop    = s.vld[0] & i_out_ready;
        push   = i_in_valid & s.rdy;
        placed = 1'b0;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_s.mem[i] = s.mem[i+1];
                next_s.vld[i] = s.vld[i+1];
            end
            next_s.vld[DEPTH-1] = 1'b0;
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !placed && !next_s.vld[i]) begin
                next_s.vld[i] = 1'b1;
                next_s.mem[i] = i_in_data;
                placed        = 1'b1;
            end
        end
        next_s.rdy = ~next_s.vld[DEPTH-1]; // full blocks the source
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s     <= '0;
            s.rdy <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign o_in_ready  = s.rdy;
    assign o_out_valid = s.vld[0];
    assign o_out_data  = s.mem[0];
endmodule : efr_fifo

module efr_rewriter_tables
    import efr_pkg::*;
#(
    parameter int NPORT      = 13,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    input  wire efr_avs_req_type i_avs,
    output var  logic [31:0]     o_avs_readdata,
    output var  logic            o_avs_waitrequest,
    input  wire logic            i_meta_valid,
    output var  logic            o_meta_ready,
    input  wire efr_meta_type    i_meta,
    output var  logic            o_edit_valid,
    input  wire logic            i_edit_ready,
    output var  efr_edit_type    o_edit
);
    typedef struct packed {
        logic [NPORT-1:0][15:0][3:0] pmap;
        logic [NPORT-1:0][7:0]       ptp;
        logic [NPORT-1:0][31:0]      dly;
        logic [63:0][5:0]            dp1;
        logic [63:0][5:0]            rmp;
        logic [1:0]                  stat;
        logic [2:0][31:0]            prot;
        logic [31:0]                 rdata;
        logic                        wreq;
    } efr_top_state_type;

    efr_top_state_type s;
    efr_top_state_type next_s;
    efr_dec_type       dec;
    efr_edit_type      res;
    logic              req;
    logic [31:0]       rv;
    logic [31:0]       wv;
    logic [3:0]        ent;
    logic [7:0]        pctl;
    logic [75:0]       prot_flat;

    // address decode, shared by read and write paths
    function automatic efr_dec_type decode(input logic [11:0] a);
        efr_dec_type d;
        logic [11:0] rel;
        logic [6:0]  ofs;
        d.kind = EFR_REG_NONE;
        d.port = a[10:7];
        d.idx  = 6'h00;
        rel    = a - `EFR_COM_BASE;
        ofs    = a[6:0];
        if (a[1:0] != 2'h0) begin
            d.kind = EFR_REG_NONE;
        end else if (a < `EFR_PROT_BASE) begin
            if (32'(a[11:`EFR_PORT_SHIFT]) < NPORT) begin
                if (ofs >= `EFR_MAP_OFS && ofs < `EFR_MAP_END) begin
                    d.kind = EFR_REG_MAP;
                    d.idx  = {2'h0, 4'(ofs[5:2] - `EFR_MAP_OFS / 4)};
                end else if (ofs == `EFR_PTP_OFS) begin
                    d.kind = EFR_REG_PTP;
                end else if (ofs == `EFR_DLY_OFS) begin
                    d.kind = EFR_REG_DLY;
                end
            end
        end else if (a < `EFR_COM_BASE) begin
            if (a[3:2] < `EFR_PROT_WORDS) begin
                d.kind = EFR_REG_PROT;
                d.idx  = {4'h0, a[3:2]};
            end
        end else if (rel < `EFR_RMP_OFS) begin
            d.kind = EFR_REG_DP1;
            d.idx  = rel[7:2];
        end else if (rel < `EFR_STAT_OFS) begin
            d.kind = EFR_REG_RMP;
            d.idx  = rel[7:2];
        end else if (rel == `EFR_STAT_OFS) begin
            d.kind = EFR_REG_STAT;
        end
        return d;
    endfunction : decode

    // byte-lane merge for partial writes
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // register read value and merged write value for the addressed word
    always_comb begin
        dec = decode(i_avs.address);
        rv  = `EFR_REG_RESET;
        case (dec.kind)
            EFR_REG_MAP:  rv = {28'h0, s.pmap[dec.port][dec.idx[3:0]]};
            EFR_REG_PTP:  rv = {24'h0, s.ptp[dec.port]};
            EFR_REG_DLY:  rv = s.dly[dec.port];
            EFR_REG_PROT: rv = s.prot[dec.idx[1:0]];
            EFR_REG_DP1:  rv = {26'h0, s.dp1[dec.idx]};
            EFR_REG_RMP:  rv = {26'h0, s.rmp[dec.idx]};
            EFR_REG_STAT: rv = {30'h0, s.stat};
            default:      rv = `EFR_REG_RESET; // unmapped reads zero
        endcase
        wv = be_merge(rv, i_avs.writedata, i_avs.byteenable);
    end

    // bus slave: waitrequest drops one cycle after a request is seen
    always_comb begin
        next_s      = s;
        req         = i_avs.read | i_avs.write;
        next_s.wreq = ~(req & s.wreq);
        if (req && s.wreq) begin
            next_s.rdata = rv;
        end
        // a write lands at the edge where waitrequest is low, so a frame
        // accepted in that same cycle still sees the old table contents
        if (i_avs.write && !s.wreq) begin
            case (dec.kind)
                EFR_REG_MAP:  next_s.pmap[dec.port][dec.idx[3:0]] = wv[3:0] & `EFR_MAP_MASK;
                EFR_REG_PTP:  next_s.ptp[dec.port] = wv[7:0] & `EFR_PTP_MASK;
                EFR_REG_DLY:  next_s.dly[dec.port] = wv;
                EFR_REG_PROT: begin
                    if (dec.idx[1:0] == 2'h2) begin
                        next_s.prot[2] = wv & `EFR_PPT2_MASK;
                    end else begin
                        next_s.prot[dec.idx[1:0]] = wv;
                    end
                end
                EFR_REG_DP1:  next_s.dp1[dec.idx] = wv[5:0];
                EFR_REG_RMP:  next_s.rmp[dec.idx] = wv[5:0];
                EFR_REG_STAT: next_s.stat = wv[1:0];
                default:      next_s.stat = s.stat; // unmapped writes ignored
            endcase
        end
    end

    // per-frame decision: every table lookup is made in the accept cycle
    always_comb begin
        ent      = s.pmap[i_meta.port][{i_meta.dp, i_meta.qos}];
        pctl     = s.ptp[i_meta.port];
        prot_flat = {s.prot[2][11:0], s.prot[1], s.prot[0]};
        res      = '0;
        res.port = i_meta.port;
        // priority code selection
        case (i_meta.tag_pcp_src)
            `EFR_SRC_CLS:    res.pcp = i_meta.cls_pcp;
            `EFR_SRC_FIXED:  res.pcp = i_meta.port_pcp;
            `EFR_SRC_MAPPED: res.pcp = ent[2:0];
            default:         res.pcp = i_meta.qos;
        endcase
        // drop eligible selection
        case (i_meta.tag_dei_src)
            `EFR_SRC_CLS:    res.dei = i_meta.cls_dei;
            `EFR_SRC_FIXED:  res.dei = i_meta.port_dei;
            `EFR_SRC_MAPPED: res.dei = ent[`EFR_MAP_DEI_BIT];
            default:         res.dei = i_meta.dp;
        endcase
        // dscp rewrite from the analyzer value or through the shared remap tables
        res.dscp_upd = (i_meta.dscp_mode != `EFR_DSCP_KEEP);
        case (i_meta.dscp_mode)
            `EFR_DSCP_ANA: res.dscp = i_meta.dscp;
            `EFR_DSCP_RMP: res.dscp = s.rmp[i_meta.dscp];
            `EFR_DSCP_DP: begin
                if (i_meta.dp) begin
                    res.dscp = s.dp1[i_meta.dscp];
                end else begin
                    res.dscp = s.rmp[i_meta.dscp];
                end
            end
            default:       res.dscp = i_meta.dscp;
        endcase
        // precision time controls
        res.bp_ts_ins = pctl[`EFR_PTP_BP_BIT];
        res.bp_ts_ofs = `EFR_BP_TS_OFS;
        res.rx_ts     = i_meta.rx_ts;
        res.one_step  = (i_meta.ptp_cmd == EFR_PTP_ONE) & ~pctl[`EFR_PTP_1S_BIT];
        res.origin    = (i_meta.ptp_cmd == EFR_PTP_ORIGIN) & ~pctl[`EFR_PTP_1S_BIT];
        res.save_departure = (i_meta.ptp_cmd == EFR_PTP_TWO) & ~pctl[`EFR_PTP_2S_BIT];
        res.residence = i_meta.residence;
        if (res.one_step && i_meta.rewrite_op[`EFR_REWOP_DLY]) begin
            res.residence = i_meta.residence + s.dly[i_meta.port];
        end
        // egress statistics counter set
        case (s.stat)
            `EFR_STAT_ES_IS: begin
                res.stat_ena = 1'b1;
                res.stat_idx = i_meta.egress_lookup_hit ? i_meta.egress_service_index
                                                        : i_meta.ingress_service_index;
            end
            `EFR_STAT_ES_ONLY: begin
                res.stat_ena = i_meta.egress_lookup_hit;
                res.stat_idx = i_meta.egress_service_index;
            end
            `EFR_STAT_IS: begin
                res.stat_ena = 1'b1;
                res.stat_idx = i_meta.ingress_service_index;
            end
            default: begin
                res.stat_ena = 1'b1;
                res.stat_idx = {3'h0, i_meta.source_port_number, i_meta.qos};
            end
        endcase
        // path protection: 0 working, 1 protected
        if (i_meta.protection_group_index < `EFR_PROT_GROUPS) begin
            res.protected_path = prot_flat[i_meta.protection_group_index];
        end
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s      <= '0;
            s.wreq <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // decided edits queue toward the egress datapath
    efr_fifo #(
        .WIDTH ($bits(efr_edit_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk       (i_clk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (i_meta_valid),
        .o_in_ready  (o_meta_ready),
        .i_in_data   (res),
        .o_out_valid (o_edit_valid),
        .i_out_ready (i_edit_ready),
        .o_out_data  (o_edit)
    );

    assign o_avs_readdata    = s.rdata;
    assign o_avs_waitrequest = s.wreq;
endmodule : efr_rewriter_tables

`default_nettype wire

// File: tb/efr_tables_properties.sv
// efr_tables_properties.sv: port-level checks of the rewriter tables.
// assumes it is bound onto efr_rewriter_tables, one clock, async reset.
`include "efr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module efr_tables_chk
    import efr_pkg::*;
(
    input wire logic            i_clk,
    input wire logic            i_rst_n,
    input wire efr_avs_req_type i_avs,
    input wire logic            o_avs_waitrequest,
    input wire logic            i_meta_valid,
    input wire logic            o_meta_ready,
    input wire efr_meta_type    i_meta,
    input wire logic            o_edit_valid,
    input wire logic            i_edit_ready,
    input wire efr_edit_type    o_edit
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a frame taken while the fifo is empty shows at the head next cycle
    logic take;
    assign take = i_meta_valid && o_meta_ready && !o_edit_valid;
    chk_edit_next: assert property (
        take |=> o_edit_valid && o_edit.port == $past(i_meta.port))
        else $error("no edit after an accepted frame");
    chk_class_pcp: assert property (
        take && i_meta.tag_pcp_src == `EFR_SRC_CLS |=> o_edit.pcp == $past(i_meta.cls_pcp))
        else $error("classified pcp not passed");
    chk_port_dei: assert property (
        take && i_meta.tag_dei_src == `EFR_SRC_FIXED |=> o_edit.dei == $past(i_meta.port_dei))
        else $error("port dei not passed");
    chk_no_ptp: assert property (
        take && i_meta.ptp_cmd == EFR_PTP_NONE
        |=> !(o_edit.one_step || o_edit.origin || o_edit.save_departure))
        else $error("timing action without a command");
    chk_resid_pass: assert property (
        take && i_meta.ptp_cmd != EFR_PTP_ONE |=> o_edit.residence == $past(i_meta.residence))
        else $error("residence changed on a non one-step frame");
    chk_bp_offset: assert property (
        o_edit_valid |-> o_edit.bp_ts_ofs == `EFR_BP_TS_OFS)
        else $error("stamp offset not 16");
    chk_far_group: assert property (
        take && i_meta.protection_group_index >= 7'h4C |=> !o_edit.protected_path)
        else $error("group beyond table marked protected");
    chk_dscp_keep: assert property (
        take && i_meta.dscp_mode == `EFR_DSCP_KEEP |=> !o_edit.dscp_upd)
        else $error("dscp updated in keep mode");
    chk_edit_hold: assert property (
        o_edit_valid && !i_edit_ready |=> o_edit_valid && $stable(o_edit))
        else $error("edit changed while stalled");
    chk_wait_pulse: assert property (
        (i_avs.read || i_avs.write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");
    // main scenarios
    cov_mapped: cover property (take && i_meta.tag_pcp_src == `EFR_SRC_MAPPED);
    cov_refused: cover property (i_meta_valid && !o_meta_ready);
    cov_write: cover property (i_avs.write && !o_avs_waitrequest);
endmodule : efr_tables_chk
bind efr_rewriter_tables efr_tables_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs(i_avs),
    .o_avs_waitrequest(o_avs_waitrequest), .i_meta_valid(i_meta_valid),
    .o_meta_ready(o_meta_ready), .i_meta(i_meta), .o_edit_valid(o_edit_valid),
    .i_edit_ready(i_edit_ready), .o_edit(o_edit));
`default_nettype wire

// File: tb/efr_egress_sink.sv
// efr_egress_sink.sv: egress port model that takes edited frames.
// assumes the bench picks its pace: prompt, stalled or slow at random.
`timescale 1ns/1ps
`default_nettype none
module efr_egress_sink (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_pace,
    output var  logic       o_edit_ready
);
    // ready changes only after an edge
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_edit_ready <= 1'b0;
        end else if (i_pace == 2'h0) begin
            o_edit_ready <= 1'b1;
        end else if (i_pace == 2'h1) begin
            o_edit_ready <= 1'b0;
        end else begin
            o_edit_ready <= ($urandom % 4) == 0;
        end
    end
endmodule : efr_egress_sink
`default_nettype wire

// File: tb/efr_rewriter_tables_tb.sv
// efr_rewriter_tables_tb.sv: self-checking bench for the rewriter tables.
// assumes efr_pkg, the checker and the egress sink model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module efr_rewriter_tables_tb
    import efr_pkg::*;
;
    logic            i_clk, i_rst_n, wreq, meta_valid, meta_ready, edit_valid, edit_ready;
    logic [1:0]      pace;
    logic [31:0]     rdata, d;
    logic [159:0]    r;
    efr_avs_req_type avs;
    efr_meta_type    m, meta;
    efr_edit_type    edit;
    efr_edit_type    exp_q [$];
    logic [3:0]      map_sh [0:3][0:15];
    logic [7:0]      ptp_sh [0:3];
    logic [31:0]     dly_sh [0:3];
    logic [31:0]     prot_sh [0:2];
    logic [5:0]      dp1_sh [0:63];
    logic [5:0]      rmp_sh [0:63];
    logic [1:0]      stat_sh;
    logic [31:0]     ptp_v [0:3] = '{32'h0, 32'h84, 32'hFFFFFF02, 32'hFFFFFFFF};
    logic [11:0]     rst_a [0:7] = '{12'h010, 12'h650, 12'h1D4, 12'h688, 12'h690, 12'h88C,
                                     12'h890, 12'hFFC};
    int              miscompares, total_checks, cycles;

    efr_rewriter_tables #(.NPORT(13), .FIFO_DEPTH(4)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_avs(avs), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_meta_valid(meta_valid), .o_meta_ready(meta_ready), .i_meta(meta),
        .o_edit_valid(edit_valid), .i_edit_ready(edit_ready), .o_edit(edit));
    efr_egress_sink u_sink (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pace(pace),
        .o_edit_ready(edit_ready));

    always #10 i_clk = ~i_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [127:0] e, input logic [127:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h got %h", what, e, g);
        end
    endtask : check

    // don't-care fields cleared before an edit is compared
    function automatic efr_edit_type norm(input efr_edit_type e);
        efr_edit_type n;
        n = e;
        n.dscp = e.dscp_upd ? e.dscp : 6'h0;
        n.stat_idx = e.stat_ena ? e.stat_idx : 10'h0;
        n.rx_ts = e.bp_ts_ins ? e.rx_ts : 32'h0;
        return n;
    endfunction : norm

    task automatic cmp_edit(input efr_edit_type e, input efr_edit_type g);
        check("edit", 128'(norm(e)), 128'(norm(g)));
    endtask : cmp_edit

    // expected edit from the shadow tables
    function automatic efr_edit_type predict(input efr_meta_type f);
        efr_edit_type e;
        logic [3:0]   mp;
        logic [7:0]   pc;
        logic [6:0]   g;
        mp = map_sh[f.port][{f.dp, f.qos}];
        pc = ptp_sh[f.port];
        e = '0;
        e.port = f.port;
        e.pcp = f.tag_pcp_src == 2'h0 ? f.cls_pcp : f.tag_pcp_src == 2'h1 ? f.port_pcp :
                f.tag_pcp_src == 2'h2 ? mp[2:0] : f.qos;
        e.dei = f.tag_dei_src == 2'h0 ? f.cls_dei : f.tag_dei_src == 2'h1 ? f.port_dei :
                f.tag_dei_src == 2'h2 ? mp[3] : f.dp;
        e.dscp_upd = f.dscp_mode != 2'h0;
        e.dscp = f.dscp_mode == 2'h1 ? f.dscp :
                 (f.dscp_mode == 2'h3 && f.dp) ? dp1_sh[f.dscp] : rmp_sh[f.dscp];
        e.bp_ts_ins = pc[7];
        e.bp_ts_ofs = 8'h10;
        e.rx_ts = f.rx_ts;
        e.one_step = f.ptp_cmd == EFR_PTP_ONE && !pc[2];
        e.origin = f.ptp_cmd == EFR_PTP_ORIGIN && !pc[2];
        e.save_departure = f.ptp_cmd == EFR_PTP_TWO && !pc[1];
        e.residence = f.residence +
                      ((e.one_step && f.rewrite_op[5]) ? dly_sh[f.port] : 32'h0);
        e.stat_ena = stat_sh != 2'h1 || f.egress_lookup_hit;
        e.stat_idx = stat_sh == 2'h3 ? {3'h0, f.source_port_number, f.qos} :
                     (stat_sh == 2'h2 || !f.egress_lookup_hit) ? f.ingress_service_index :
                     f.egress_service_index;
        g = f.protection_group_index;
        e.protected_path = g < 7'h4C ? prot_sh[g / 32][g % 32] : 1'b0;
        return e;
    endfunction : predict

    // one bus access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        avs <= '{a, !wr, wr, wd, 4'hF};
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdata;
        avs <= '{a, 1'b0, 1'b0, wd, 4'hF};
        @(posedge i_clk);
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check("register", 128'(e), 128'(q));
    endtask : rd

    task automatic wrd(input logic [11:0] a, input logic [31:0] wd, input logic [31:0] k,
                       output logic [31:0] s);
        logic [31:0] q;
        bus(1'b1, a, wd, q);
        rd(a, wd & k);
        s = wd & k;
    endtask : wrd

    task automatic send(input efr_meta_type f);
        meta_valid <= 1'b1;
        meta <= f;
        do @(posedge i_clk); while (meta_ready !== 1'b1);
        exp_q.push_back(predict(f));
    endtask : send

    task automatic drain();
        meta_valid <= 1'b0;
        do @(posedge i_clk); while (exp_q.size() != 0);
        @(posedge i_clk);
    endtask : drain

    function automatic efr_meta_type rnd_meta();
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        rnd_meta = r[131:0];
        rnd_meta.port[3:2] = 2'h0;
    endfunction : rnd_meta

    // scoreboard: each handed-over edit is matched against the oldest note
    always @(posedge i_clk) begin
        if (i_rst_n === 1'b1 && edit_valid === 1'b1 && edit_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("ERROR edit expected none got %h", edit);
            end else begin
                cmp_edit(exp_q.pop_front(), edit);
            end
        end
    end

    // hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        void'($urandom(5));
        i_clk = 1'b0;
        i_rst_n = 1'b0;
        avs = '0;
        meta_valid = 1'b0;
        meta = '0;
        pace = 2'h0;
        stat_sh = 2'h0;
        map_sh = '{default: '0};
        ptp_sh = '{default: '0};
        dly_sh = '{default: '0};
        prot_sh = '{default: '0};
        dp1_sh = '{default: '0};
        rmp_sh = '{default: '0};
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        for (int i = 0; i < 8; i++) rd(rst_a[i], 32'h0);
        $display("test reset values done");
        for (int p = 0; p < 4; p++) begin
            for (int e = 0; e < 16; e++) begin
                wrd(12'(p * 128 + 16 + e * 4), $urandom, 32'hF, d);
                map_sh[p][e] = d[3:0];
            end
            wrd(12'(p * 128 + 80), ptp_v[p], 32'h86, d);
            ptp_sh[p] = d[7:0];
            wrd(12'(p * 128 + 84), $urandom, 32'hFFFFFFFF, dly_sh[p]);
        end
        for (int i = 0; i < 64; i++) begin
            wrd(12'(12'h690 + i * 4), $urandom, 32'h3F, d);
            dp1_sh[i] = d[5:0];
            wrd(12'(12'h790 + i * 4), $urandom, 32'h3F, d);
            rmp_sh[i] = d[5:0];
        end
        for (int i = 0; i < 3; i++) begin
            wrd(12'(12'h680 + i * 4), $urandom, (i == 2) ? 32'hFFF : 32'hFFFFFFFF,
                prot_sh[i]);
        end
        wrd(12'hFFC, $urandom, 32'h0, d);
        $display("test register access done");
        for (int s = 0; s < 4; s++) begin
            wrd(12'h890, 32'(s), 32'h3, d);
            stat_sh = d[1:0];
            pace <= s[0] ? 2'h2 : 2'h0;
            for (int k = 0; k < 32; k++) begin
                m = rnd_meta();
                m.tag_pcp_src = k[1:0];
                m.tag_dei_src = k[3:2];
                m.dscp_mode = k[2:1];
                m.ptp_cmd = efr_ptp_cmd_type'(k[4:3]);
                send(m);
                if (k[0]) begin
                    meta_valid <= 1'b0; // gap so the next frame meets an empty queue when the sink is prompt
                    repeat (2) @(posedge i_clk);
                end
            end
            drain();
        end
        $display("test frame editing done");
        pace <= 2'h1;
        repeat (2) @(posedge i_clk);
        for (int k = 0; k < 4; k++) send(rnd_meta());
        meta_valid <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("meta_ready", 128'h0, 128'(meta_ready));
        pace <= 2'h0;
        drain();
        check("edit_valid", 128'h0, 128'(edit_valid));
        $display("test buffer full done");
        print_verdict();
    end
endmodule : efr_rewriter_tables_tb
`default_nettype wire
